// ===== core/amp_ctrl_pkg.sv
// Shared constants, state encoding and timing for the amplifier control block
// Functional notes
// R01: Once bias reference settles, run fixed start-up timer; switch only after expiry.
// R02: Same bias-then-timer start-up at power-up and on leaving shutdown.
// R03: Shutdown input low mutes outputs and enters the low-current state.
// R04: Mute input high disables outputs; mute low enables them.
// R05: Any detected output short disables drive at once and latches.
// R06: Short flag clears only by cycling shutdown or mute, then operation resumes.
// R07: A short still present after clearing is detected again and relatched.
// R08: Fault output is high while the short flag is set.
// R09: Mute rising clears the fault flag, allowing fault-to-mute auto-recovery loop.
// R10: Master-select high uses internal oscillator and drives sync pin push-pull.
// R11: Master-select low takes switching frequency from the incoming sync square wave.
// R12: External sync source in slave mode should stay within 200 to 300 kHz.
// R13: Die temperature above trip point forces shutdown state; fault not latched.
// R14: Thermal fault clears after temperature falls by hysteresis, resuming automatically.
// R15: Master frequency is one over twice oscillator resistor times internal capacitor.
// R16: Host wanting own mute plus auto-recovery ORs its mute with fault.
// R17: Host should shut down or mute before removing supply power.
// R18: Shutdown during running start-up timer aborts it; full sequence restarts later.
package amp_ctrl_pkg;

	localparam int CLK_PERIOD_NS = 40;

	// Start-up delay, in microseconds
	localparam int STARTUP_US  = 16_400;
	localparam int STARTUP_CYC = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Thermal trip and hysteresis, degrees C
	localparam logic [7:0] TEMP_TRIP_C = 8'h96;
	localparam logic [7:0] TEMP_HYST_C = 8'h1E;

	// Internal oscillator capacitor in pF, default resistor in ohm
	localparam int OSC_CAP_PF  = 20;
	localparam int OSC_RES_OHM = 100_000;
	// Half period R*C: ohm*pF gives ps
	localparam int OSC_HALF_NS = OSC_RES_OHM * OSC_CAP_PF / 1000;
	localparam int OSC_HALF_CYC_RAW = OSC_HALF_NS / CLK_PERIOD_NS;
	localparam int OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 : OSC_HALF_CYC_RAW;

	// Pin positions in the synchroniser vector
	localparam int PIN_SHDN   = 0;
	localparam int PIN_MUTE   = 1;
	localparam int PIN_MASTER = 2;
	localparam int PIN_SYNC   = 3;
	localparam int PIN_SHORT  = 4;
	localparam int PIN_BIAS   = 5;
	localparam int PIN_COUNT  = 6;

	// Reset value of the synchronised pins: shutdown asserted, rest low
	localparam logic [PIN_COUNT-1:0] PINS_RESET = 6'h00;

	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_BIAS  = 2'b01,
		ST_TIMER = 2'b10,
		ST_RUN   = 2'b11
	} seq_e;

endpackage : amp_ctrl_pkg

// ===== core/switch_clk_if.sv
// Link between sequencer and switching clock generator
`timescale 1ns/1ns
`default_nettype none
interface switch_clk_if;
	logic master;
	logic run;
	logic sync_in;
	logic pwm;
	logic sync_out;
	logic sync_oe;

	modport gen  (input master, input run, input sync_in,
		output pwm, output sync_out, output sync_oe);
	modport ctrl (output master, output run, output sync_in,
		input pwm, input sync_out, input sync_oe);
endinterface : switch_clk_if
`default_nettype wire

// ===== core/switch_clock_gen.sv
// Switching clock generator: internal RC oscillator or follower of the sync pin
`timescale 1ns/1ns
`default_nettype none
module switch_clock_gen
	import amp_ctrl_pkg::*;
#(
	parameter int HALF_CYC = OSC_HALF_CYC
) (
	input  wire logic   clk_sys,
	input  wire logic   resetn,
	switch_clk_if.gen   sw
);
	localparam int HW = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);

	typedef struct packed {
		logic [HW-1:0] cnt;
		logic          osc;
		logic          pwm;
		logic          so;
		logic          oe;
	} gen_s;

	gen_s q;
	gen_s d;

	always_comb begin
		d = q;
		// Push-pull drive only in master mode
		d.oe = sw.master; // see R10
		d.so = sw.master & q.osc; // see R10
		if (sw.master) begin
			// Toggle every R*C: period 2*R*C
			if (q.cnt == HW'(HALF_CYC - 1)) begin // see R15
				d.cnt = '0;
				d.osc = ~q.osc;
			end else begin
				d.cnt = q.cnt + HW'(1);
			end
		end else begin
			d.cnt = '0;
			d.osc = 1'b0;
		end
		// Slave follows incoming square wave
		d.pwm = sw.run & (sw.master ? q.osc : sw.sync_in); // see R11
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sw.pwm      = q.pwm;
	assign sw.sync_out = q.so;
	assign sw.sync_oe  = q.oe;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	chk_master_drives: assert property (sw.master |=> sw.sync_oe && sw.sync_out == $past(q.osc)) // see R10
		else $error("sync pin not driven in master mode");
	chk_slave_follows: assert property (!sw.master |=> !sw.sync_oe
		&& sw.pwm == $past(sw.run & sw.sync_in)) // see R11
		else $error("slave switching does not follow sync input");
	chk_osc_period: assert property (sw.master && $past(sw.master) && $changed(q.osc)
		&& HALF_CYC > 1 |=> !$changed(q.osc)) // see R15
		else $error("oscillator toggles too fast");

endmodule : switch_clock_gen
`default_nettype wire

// ===== core/amp_power_fault_sync_ctrl.sv
// Start-up sequencing, shutdown, mute, short and thermal protection, sync control
`timescale 1ns/1ns
`default_nettype none
module amp_power_fault_sync_ctrl
	import amp_ctrl_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC,
	parameter int OSC_HALF       = OSC_HALF_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       shutdown_n,
	input  wire logic       mute,
	input  wire logic       master_select,
	input  wire logic       sync_in,
	input  wire logic       short_detect,
	input  wire logic       bias_ready,
	input  wire logic [7:0] die_temp_c,
	output logic            outputs_enable,
	output logic            low_power,
	output logic            fault_out,
	output logic            thermal_shutdown,
	output logic            startup_busy,
	output logic            pwm_clk,
	output logic            sync_out,
	output logic            sync_oe
);
	localparam int TW = $clog2(STARTUP_CYCLES + 1);

	// Start-up in progress: waiting for bias or counting
	function automatic logic is_starting(input seq_e s);
		return (s == ST_BIAS) || (s == ST_TIMER);
	endfunction : is_starting

	typedef struct packed {
		logic [PIN_COUNT-1:0] s1;
		logic [PIN_COUNT-1:0] s2;
		logic [PIN_COUNT-1:0] s3;
		logic [PIN_COUNT-1:0] filt;
		seq_e                 st;
		logic [TW-1:0]        cnt;
		logic                 mute_prev;
		logic                 short_q;
		logic                 therm_q;
		logic                 en_q;
		logic                 lp_q;
		logic                 busy_q;
	} ctrl_s;

	ctrl_s q;
	ctrl_s d;

	logic [PIN_COUNT-1:0] pins;
	logic shdn;
	logic mute_f;
	logic short_f;
	logic bias_f;
	logic mute_rise;

	switch_clk_if sw ();

	assign pins = {bias_ready, short_detect, sync_in, master_select, mute, shutdown_n};
	assign shdn      = q.filt[PIN_SHDN];
	assign mute_f    = q.filt[PIN_MUTE];
	assign short_f   = q.filt[PIN_SHORT];
	assign bias_f    = q.filt[PIN_BIAS];
	assign mute_rise = mute_f & ~q.mute_prev;

	always_comb begin
		d = q;
		// Three-stage synchroniser; a change counts when stages two and three agree
		d.s1   = pins;
		d.s2   = q.s1;
		d.s3   = q.s2;
		d.filt = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
		d.mute_prev = mute_f;

		// Thermal fault with hysteresis, not latched
		if (die_temp_c > TEMP_TRIP_C) begin
			d.therm_q = 1'b1; // see R13
		end else if (die_temp_c <= TEMP_TRIP_C - TEMP_HYST_C) begin
			d.therm_q = 1'b0; // see R14
		end

		// Start-up sequence
		case (q.st)
			ST_OFF: begin
				d.cnt = '0;
				if (shdn && !d.therm_q) begin
					d.st = ST_BIAS; // see R02
				end
			end
			ST_BIAS: begin
				d.cnt = '0;
				if (bias_f) begin
					d.st = ST_TIMER; // see R01
				end
			end
			ST_TIMER: begin
				if (q.cnt == TW'(STARTUP_CYCLES - 1)) begin
					d.st = ST_RUN; // see R01
				end else begin
					d.cnt = q.cnt + TW'(1);
				end
			end
			ST_RUN: begin
				d.cnt = '0;
			end
			default: begin
				d.st  = ST_OFF;
				d.cnt = '0;
			end
		endcase
		// Shutdown or thermal fault aborts anything in progress
		if (!shdn || d.therm_q) begin
			d.st  = ST_OFF; // see R03, R13, R18
			d.cnt = '0;
		end

		// Latched short fault; a fresh detection wins over a clear
		if (!shdn || mute_rise) begin
			d.short_q = 1'b0; // see R06, R09
		end
		if (short_f && q.en_q) begin
			d.short_q = 1'b1; // see R05, R07
		end

		d.en_q   = (d.st == ST_RUN) && !mute_f && !d.short_q && !d.therm_q; // see R04, R05
		d.lp_q   = (d.st == ST_OFF); // see R03
		d.busy_q = is_starting(d.st);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q.s1        <= PINS_RESET;
			q.s2        <= PINS_RESET;
			q.s3        <= PINS_RESET;
			q.filt      <= PINS_RESET;
			q.st        <= ST_OFF;
			q.cnt       <= '0;
			q.mute_prev <= 1'b0;
			q.short_q   <= 1'b0;
			q.therm_q   <= 1'b0;
			q.en_q      <= 1'b0;
			q.lp_q      <= 1'b1;
			q.busy_q    <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign sw.master  = q.filt[PIN_MASTER];
	assign sw.sync_in = q.filt[PIN_SYNC];
	assign sw.run     = q.en_q;

	switch_clock_gen #(
		.HALF_CYC (OSC_HALF)
	) u_clk (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.sw      (sw.gen)
	);

	assign outputs_enable   = q.en_q;
	assign low_power        = q.lp_q;
	assign fault_out        = q.short_q; // see R08
	assign thermal_shutdown = q.therm_q;
	assign startup_busy     = q.busy_q;
	assign pwm_clk          = sw.pwm;
	assign sync_out         = sw.sync_out;
	assign sync_oe          = sw.sync_oe;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	chk_run_after_timer: assert property ($rose(q.st == ST_RUN) |->
		$past(q.st) == ST_TIMER && $past(q.cnt) == TW'(STARTUP_CYCLES - 1)) // see R01
		else $error("switching started before start-up timer expired");
	chk_timer_needs_bias: assert property ($rose(q.st == ST_TIMER) |-> $past(bias_f)) // see R02
		else $error("start-up timer began without bias reference");
	chk_shutdown_lowpwr: assert property (!shdn |=> low_power && !outputs_enable) // see R03
		else $error("shutdown did not force low-current state");
	chk_mute_disables: assert property (mute_f |=> !outputs_enable) // see R04
		else $error("outputs enabled while muted");
	chk_short_latches: assert property (short_f && outputs_enable |=> fault_out && !outputs_enable) // see R05
		else $error("short did not latch fault and disable drive");
	chk_short_holds: assert property (fault_out && shdn && !mute_rise |=> fault_out) // see R06
		else $error("short flag cleared without shutdown or mute cycle");
	chk_mute_clears: assert property (fault_out && mute_rise && !(short_f && q.en_q)
		|=> !fault_out) // see R09
		else $error("mute rising did not clear fault flag");
	chk_thermal_trip: assert property (die_temp_c > TEMP_TRIP_C |=> thermal_shutdown
		&& low_power && !outputs_enable) // see R13
		else $error("over-temperature did not shut down");
	chk_thermal_release: assert property (thermal_shutdown && die_temp_c <= TEMP_TRIP_C - TEMP_HYST_C
		|=> !thermal_shutdown) // see R14
		else $error("thermal fault not released after hysteresis");
	chk_abort_timer: assert property (q.st == ST_TIMER && !shdn |=> q.st == ST_OFF && q.cnt == '0) // see R18
		else $error("shutdown did not abort start-up timer");

	chk_starting_quiet: assert property (is_starting(q.st) |-> !outputs_enable && startup_busy) // see R01
		else $error("outputs enabled during start-up");
	chk_timer_counts: assert property (q.st == ST_TIMER && q.cnt != TW'(STARTUP_CYCLES - 1)
		|=> q.st == ST_OFF || q.cnt == $past(q.cnt) + TW'(1)) // see R01
		else $error("start-up timer skipped or stalled");
	chk_restart_sequence: assert property ($fell(low_power) |-> startup_busy) // see R02
		else $error("left low-current state without start-up sequence");
	chk_lowpwr_in_off: assert property (q.st == ST_OFF |-> low_power) // see R03
		else $error("off state without low-current flag");
	chk_pwm_gated: assert property (!outputs_enable |=> !pwm_clk) // see R04
		else $error("switching clock running with outputs disabled");
	chk_short_needs_drive: assert property ($rose(fault_out) |->
		$past(outputs_enable) && $past(short_f)) // see R05
		else $error("fault latched without a short while driving");

	chk_thermal_holds_off: assert property (thermal_shutdown |-> low_power && !outputs_enable) // see R13
		else $error("outputs enabled during thermal fault");
	chk_thermal_hyst: assert property (thermal_shutdown && die_temp_c > TEMP_TRIP_C - TEMP_HYST_C
		|=> thermal_shutdown) // see R14
		else $error("thermal fault released inside hysteresis band");

endmodule : amp_power_fault_sync_ctrl
`default_nettype wire

// ===== verification/amp_host_partner.sv
// Host mute gating and companion sync source on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module amp_host_partner #(
	parameter int HALF = 50
) (
	input  wire logic clk_sys,
	input  wire logic host_mute,
	input  wire logic fault_out,
	input  wire logic sync_out,
	input  wire logic sync_oe,
	output logic      mute,
	output logic      sync_in
);
	logic sq_q = 1'b0;
	int   cnt_q = 0;
	// Companion square wave, 250 kHz
	always @(posedge clk_sys) begin
		cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
		if (cnt_q == HALF - 1) begin
			sq_q <= ~sq_q;
		end
	end
	assign mute    = host_mute | fault_out;
	assign sync_in = sync_oe ? sync_out : sq_q;
endmodule : amp_host_partner
`default_nettype wire

// ===== verification/amp_power_fault_sync_ctrl_tb.sv
// Self-checking bench for the amplifier control block
`timescale 1ns/1ns
`default_nettype none
module amp_power_fault_sync_ctrl_tb;
	localparam int OE = 0, LP = 1, FO = 2, TS = 3, SB = 4, PW = 5, SO = 6, SE = 7;
	logic       clk_sys = 1'b0;
	logic       resetn = 1'b0;
	logic       shutdown_n = 1'b0;
	logic       host_mute = 1'b0;
	logic       mute;
	logic       master_select = 1'b0;
	logic       sync_in;
	logic       short_detect = 1'b0;
	logic       bias_ready = 1'b0;
	logic [7:0] die_temp_c = 8'h19;
	logic       outputs_enable, low_power, fault_out, thermal_shutdown;
	logic       startup_busy, pwm_clk, sync_out, sync_oe;
	logic [7:0] obs;
	int         n_fail = 0;
	int         checks = 0;

	assign obs = {sync_oe, sync_out, pwm_clk, startup_busy, thermal_shutdown, fault_out,
		low_power, outputs_enable};

	always #20 clk_sys = ~clk_sys;

	amp_power_fault_sync_ctrl #(.STARTUP_CYCLES(20), .OSC_HALF(3)) u_amp_power_fault_sync_ctrl (
		.clk_sys(clk_sys), .resetn(resetn), .shutdown_n(shutdown_n), .mute(mute),
		.master_select(master_select), .sync_in(sync_in), .short_detect(short_detect),
		.bias_ready(bias_ready), .die_temp_c(die_temp_c), .outputs_enable(outputs_enable),
		.low_power(low_power), .fault_out(fault_out), .thermal_shutdown(thermal_shutdown),
		.startup_busy(startup_busy), .pwm_clk(pwm_clk), .sync_out(sync_out), .sync_oe(sync_oe));

	amp_host_partner #(.HALF(50)) u_amp_host_partner (
		.clk_sys(clk_sys), .host_mute(host_mute), .fault_out(fault_out),
		.sync_out(sync_out), .sync_oe(sync_oe), .mute(mute), .sync_in(sync_in));

	task automatic complete_run();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_for(input int i, input logic v, input int lim, output int n);
		n = 0;
		while (obs[i] !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		chk(obs[i], v);
	endtask : wait_for

	task automatic half_period(input int i, input int lim, output int n);
		logic v;
		v = obs[i];
		wait_for(i, ~v, lim, n);
		wait_for(i, v, lim, n);
	endtask : half_period

	task automatic t_startup();
		int n;
		shutdown_n = 1'b1;
		wait_for(SB, 1'b1, 10, n);
		repeat (30) @(negedge clk_sys);
		chk(obs[OE], 1'b0);
		bias_ready = 1'b1;
		wait_for(OE, 1'b1, 60, n);
		chk(n >= 20, 1'b1);
		chk(obs[SB], 1'b0);
	endtask : t_startup

	task automatic t_mute();
		int n;
		host_mute = 1'b1;
		wait_for(OE, 1'b0, 8, n);
		host_mute = 1'b0;
		wait_for(OE, 1'b1, 8, n);
	endtask : t_mute

	task automatic t_short();
		int n;
		short_detect = 1'b1;
		wait_for(FO, 1'b1, 8, n);
		chk(obs[OE], 1'b0);
		wait_for(FO, 1'b0, 10, n);
		wait_for(FO, 1'b1, 20, n);
		short_detect = 1'b0;
		wait_for(OE, 1'b1, 30, n);
		repeat (10) @(negedge clk_sys);
		chk(obs[FO], 1'b0);
	endtask : t_short

	task automatic t_thermal();
		int n;
		die_temp_c = 8'h96;
		repeat (3) @(negedge clk_sys);
		chk(obs[TS], 1'b0);
		die_temp_c = 8'h97;
		@(negedge clk_sys);
		chk(obs[TS], 1'b1);
		chk({obs[OE], obs[LP]}, 2'b01);
		die_temp_c = 8'h79;
		repeat (3) @(negedge clk_sys);
		chk(obs[TS], 1'b1);
		die_temp_c = 8'h78;
		@(negedge clk_sys);
		chk(obs[TS], 1'b0);
		wait_for(OE, 1'b1, 60, n);
	endtask : t_thermal

	task automatic t_abort();
		int n;
		shutdown_n = 1'b0;
		wait_for(LP, 1'b1, 8, n);
		chk(obs[OE], 1'b0);
		shutdown_n = 1'b1;
		wait_for(SB, 1'b1, 8, n);
		repeat (10) @(negedge clk_sys);
		shutdown_n = 1'b0;
		wait_for(SB, 1'b0, 8, n);
		shutdown_n = 1'b1;
		wait_for(OE, 1'b1, 60, n);
		chk(n >= 20, 1'b1);
	endtask : t_abort

	task automatic t_sync();
		int n;
		master_select = 1'b1;
		wait_for(SE, 1'b1, 8, n);
		half_period(SO, 8, n);
		chk(n, 3);
		half_period(PW, 8, n);
		chk(n, 3);
		master_select = 1'b0;
		wait_for(SE, 1'b0, 8, n);
		repeat (10) @(negedge clk_sys);
		half_period(PW, 120, n);
		chk(n, 50);
	endtask : t_sync

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		complete_run();
	end

	initial begin
		repeat (5) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys);
		chk({obs[OE], obs[LP]}, 2'b01);
		t_startup();
		t_mute();
		t_short();
		t_thermal();
		t_abort();
		t_sync();
		shutdown_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		chk({obs[OE], obs[LP]}, 2'b01);
		complete_run();
	end
endmodule : amp_power_fault_sync_ctrl_tb
`default_nettype wire
